// >>> src/bsc_params.svh
// Constants of the bootstrap strap capture block: offsets, fields, resets.
// Assumes inclusion by the package and by every module that decodes straps.
`ifndef BSC_PARAMS_SVH
`define BSC_PARAMS_SVH

`define BSC_OFF_STRAP 8'h00
`define BSC_OFF_STAT 8'h04
`define BSC_OFF_ETH 8'h08
`define BSC_ETH_RST_INIT 2'h0
`define BSC_NPLL 3
`define BSC_STRAP_W 14
`define BSC_SYNC_W 18
`define BSC_F_DSU 8
`define BSC_F_MW 9
`define BSC_F_PR 10
`define BSC_F_CS 11
`define BSC_F_IL 12
`define BSC_F_HALT 13
`define BSC_F_EXT 14
`define BSC_F_LOCK 15
`define BSC_ETHERNET_DEBUG_LINK_OFF 4'hF

`endif

// >>> src/bsc_pkg.sv
// Types shared by the bootstrap strap capture modules.
// Assumes the constants header is on the include path.
`include "bsc_params.svh"

package bsc_pkg;

    typedef enum logic {
        BSC_RST_HOLD,
        BSC_RST_RUN
    } bsc_rst_e;

    typedef enum logic [1:0] {
        BSC_DINT_ACK,
        BSC_DINT_EXT,
        BSC_DINT_TC_ALL,
        BSC_DINT_TC_FLAG
    } bsc_dint_e;

    typedef struct packed {
        bsc_rst_e st;
        logic [`BSC_STRAP_W-1:0] strap;
        logic [1:0] eth_rst;
        logic [1:0] ethernet_debug_link_dis;
    } bsc_core_s;

    typedef struct packed {
        logic [31:0] prdata;
        logic pslverr;
    } bsc_apb_s;

endpackage

// >>> src/bsc_reg_if.sv
// Register access carrier between the APB slave and the strap core.
// Assumes one clock domain; strobes last one cycle.
`timescale 1ns/1ns

interface bsc_reg_if;
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic hit;

    modport apb (output wr, output rd, output addr, output wdata, input rdata, input hit);
    modport core (input wr, input rd, input addr, input wdata, output rdata, output hit);
endinterface

// >>> src/bsc_sync.sv
// Two-stage synchroniser for strap, lock and reset pins.
// Assumes inputs are quasi-static levels from outside the clock domain.
`timescale 1ns/1ns

module bsc_sync
    import bsc_pkg::*;
#(
    parameter int W = `BSC_SYNC_W
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } bsc_sync_s;

    bsc_sync_s q, d;

    always_comb begin
        d = q;
        d.s1 = din;
        d.s2 = q.s1;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.s2;
endmodule

// >>> src/bsc_apb.sv
// APB slave front end: zero wait states, read data registered in setup.
// Assumes the core answers rdata and hit combinationally from addr.
`timescale 1ns/1ns

module bsc_apb
    import bsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    bsc_reg_if.apb rif
);
    bsc_apb_s q, d;
    logic setup;

    assign setup = psel && !penable;
    assign rif.addr = paddr[7:0];
    assign rif.wdata = pwdata;
    // Writes act only at the completing edge of the access phase.
    assign rif.wr = psel && penable && pwrite && rif.hit && (paddr[31:8] == 24'h000000);
    assign rif.rd = setup && !pwrite;

    always_comb begin
        d = q;
        if (setup) begin
            d.pslverr = !rif.hit || (paddr[31:8] != 24'h000000) || (paddr[1:0] != 2'h0);
            // A refused read must not leak a register word through a matching low byte.
            d.prdata = (!pwrite && !d.pslverr) ? rif.rdata : 32'h00000000;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign prdata = q.prdata;
    assign pslverr = q.pslverr && psel && penable;
    assign pready = 1'b1;

    a_apb_error_zero: assert property (@(posedge clk_sys) disable iff (!rstn)
        psel && penable && pslverr |-> prdata == 32'h00000000)
        else $error("error response carries nonzero data");
endmodule

// >>> src/bsc_top.sv
// Bootstrap strap capture: on-chip reset release, strap latching, decode.
// Assumes strap, lock and reset pins are asynchronous; APB on clk_sys.
`timescale 1ns/1ns

// Behaviour
// - Latch all straps when system reset releases.
// - Release reset after external reset and PLL lock.
// - Peripherals use latched straps, not live pins, except the debug halt and the PLL gate, which follow the live halt and ignore-lock pins.
// - Debug strap high clocks debug unit and bus.
// - Debug strap low disables debug links, Ethernet clocks.
// - Halt request with debug strap halts processors.
// - Without debug strap, halt sets watchdog, first start.
// - Width strap selects 64 or 32 data bits.
// - Narrow memory gives upper pins PCI or Ethernet.
// - Clock strap picks system or external memory clock.
// - Straps form debug link address low nibbles.
// - Straps 3:0 all ones disable debug link 0.
// - Straps 7:4 all ones disable debug link 1.
// - Straps 0 and 1 drive time controller inputs.
// - Mode 00 acknowledged, 01 extended interrupts.
// - Modes 10 and 11 disable distributed interrupts.
// - Ignore-lock strap ungates PLLs, drops lock from reset.
module bsc_top
    import bsc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] gpio_strap,
    input wire logic debug_unit_enable_strap,
    input wire logic halt_request,
    input wire logic mem_width_strap,
    input wire logic pin_reuse_strap,
    input wire logic memory_clock_source_strap,
    input wire logic ignore_lock_strap,
    input wire logic external_system_reset_n,
    input wire logic [`BSC_NPLL-1:0] pll_lock,
    output logic sys_rst_n,
    output logic pll_gate_open,
    output logic debug_unit_clk_en,
    output logic debug_bus_clk_en,
    output logic [1:0] eth_clk_en,
    output logic [1:0] ethernet_debug_link_en,
    output logic [3:0] ethernet_debug_link_nibble0,
    output logic [3:0] ethernet_debug_link_nibble1,
    output logic cpu_debug_halt,
    output logic wdog_enable,
    output logic cpu0_start,
    output logic mem_data_64,
    output logic upper_pins_pci,
    output logic upper_pins_eth1,
    output logic mem_clk_external,
    output logic tdc_set_elapsed,
    output logic tdc_incr_elapsed,
    output logic dint_enable,
    output logic dint_ext_mode,
    output logic dint_tc_all,
    output logic dint_tc_flag_filter
);
    // ------------------------------------------------------------
    // Pin synchronisation
    // ------------------------------------------------------------
    logic [`BSC_SYNC_W-1:0] pins_raw;
    logic [`BSC_SYNC_W-1:0] pins_s;
    logic [`BSC_STRAP_W-1:0] strap_s;
    logic ext_ok;
    logic lock_ok;
    logic il_s;
    logic halt_s;

    assign pins_raw = {pll_lock, external_system_reset_n, halt_request, ignore_lock_strap,
                       memory_clock_source_strap, pin_reuse_strap, mem_width_strap,
                       debug_unit_enable_strap, gpio_strap};

    bsc_sync #(.W(`BSC_SYNC_W)) u_sync (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .din(pins_raw),
        .dout(pins_s)
    );

    assign strap_s = pins_s[`BSC_STRAP_W-1:0];
    assign ext_ok = pins_s[`BSC_F_EXT];
    assign il_s = pins_s[`BSC_F_IL];
    assign halt_s = pins_s[`BSC_F_HALT];
    // With the ignore-lock strap set, lock leaves reset generation entirely.
    assign lock_ok = (&pins_s[`BSC_F_LOCK +: `BSC_NPLL]) || il_s;
    assign pll_gate_open = lock_ok;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    bsc_reg_if rif ();

    bsc_apb u_apb (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .rif(rif.apb)
    );

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function automatic bsc_dint_e dint_mode(input logic [1:0] code);
        case (code)
            2'h0: dint_mode = BSC_DINT_ACK;
            2'h1: dint_mode = BSC_DINT_EXT;
            2'h2: dint_mode = BSC_DINT_TC_ALL;
            default: dint_mode = BSC_DINT_TC_FLAG;
        endcase
    endfunction

    function automatic logic ethernet_debug_link_off(input logic [`BSC_STRAP_W-1:0] s, input int i);
        ethernet_debug_link_off = (s[4*i +: 4] == `BSC_ETHERNET_DEBUG_LINK_OFF);
    endfunction

    // ------------------------------------------------------------
    // Core state
    // ------------------------------------------------------------
    bsc_core_s q, d;
    logic rel;
    logic debug_support_unit;
    bsc_dint_e mode;

    always_comb begin
        d = q;
        case (q.st)
            BSC_RST_HOLD: begin
                // Straps are sampled on the very cycle the reset is let go.
                if (ext_ok && lock_ok) begin
                    d.st = BSC_RST_RUN;
                    d.strap = strap_s;
                end
            end
            BSC_RST_RUN: begin
                // Latched straps are left alone while running.
                if (!ext_ok || !lock_ok) begin
                    d.st = BSC_RST_HOLD;
                end
            end
            default: begin
                d.st = BSC_RST_HOLD;
            end
        endcase
        if (rif.wr && rif.addr == `BSC_OFF_ETH) begin
            d.eth_rst = rif.wdata[1:0];
        end
        for (int i = 0; i < 2; i++) begin
            // Disable code is judged from the latched copy when a controller
            // leaves reset, so later pin reuse cannot change it.
            if ((q.eth_rst[i] || q.st == BSC_RST_HOLD) && !d.eth_rst[i] && d.st == BSC_RST_RUN) begin
                d.ethernet_debug_link_dis[i] = ethernet_debug_link_off(d.strap, i);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q <= '{st: BSC_RST_HOLD, strap: '0, eth_rst: `BSC_ETH_RST_INIT, ethernet_debug_link_dis: 2'h0};
        end else begin
            q <= d;
        end
    end

    assign rel = (q.st == BSC_RST_RUN);
    assign sys_rst_n = rel;
    assign debug_support_unit = q.strap[`BSC_F_DSU];
    assign mode = dint_mode(q.strap[7:6]);

    // ------------------------------------------------------------
    // Register read mux
    // ------------------------------------------------------------
    always_comb begin
        rif.hit = 1'b1;
        case (rif.addr)
            `BSC_OFF_STRAP: rif.rdata = {18'h00000, q.strap};
            `BSC_OFF_STAT: rif.rdata = {26'h0000000, halt_s, lock_ok, ext_ok, il_s, 1'b0, rel};
            `BSC_OFF_ETH: rif.rdata = {28'h0000000, q.ethernet_debug_link_dis, q.eth_rst};
            default: begin
                rif.rdata = 32'h00000000;
                rif.hit = 1'b0;
            end
        endcase
        // Read data stays quiet outside read setup cycles, so no stale word reaches the bus.
        if (!rif.rd) begin
            rif.rdata = 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // Configuration outputs, from the latched copy except cpu_debug_halt, which follows the synchronised halt_s
    // ------------------------------------------------------------
    assign debug_unit_clk_en = rel && debug_support_unit;
    assign debug_bus_clk_en = rel && debug_support_unit;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_eth
            assign eth_clk_en[g] = rel && debug_support_unit && !q.eth_rst[g];
            assign ethernet_debug_link_en[g] = eth_clk_en[g] && !q.ethernet_debug_link_dis[g];
        end
    endgenerate

    assign ethernet_debug_link_nibble0 = {q.strap[3:2], q.strap[1:0]};
    assign ethernet_debug_link_nibble1 = {q.strap[5:4], q.strap[1:0]};

    assign cpu_debug_halt = rel && debug_support_unit && halt_s;
    // Halt level is held with the straps so the watchdog bit is steady.
    assign wdog_enable = rel && !debug_support_unit && q.strap[`BSC_F_HALT];
    assign cpu0_start = rel && (debug_support_unit || q.strap[`BSC_F_HALT]);

    assign mem_data_64 = !q.strap[`BSC_F_MW];
    assign upper_pins_pci = q.strap[`BSC_F_MW] && q.strap[`BSC_F_PR];
    assign upper_pins_eth1 = q.strap[`BSC_F_MW] && !q.strap[`BSC_F_PR];
    assign mem_clk_external = q.strap[`BSC_F_CS];

    assign tdc_set_elapsed = q.strap[0];
    assign tdc_incr_elapsed = q.strap[1];

    assign dint_enable = (mode == BSC_DINT_ACK) || (mode == BSC_DINT_EXT);
    assign dint_ext_mode = (mode == BSC_DINT_EXT);
    assign dint_tc_all = (mode == BSC_DINT_TC_ALL);
    assign dint_tc_flag_filter = (mode == BSC_DINT_TC_FLAG);

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rstn);

    sequence s_release;
        !rel ##1 rel;
    endsequence

    sequence s_eth_leave(i);
        rel && q.eth_rst[i] ##1 rel && !q.eth_rst[i];
    endsequence

    a_release_needs_lock: assert property (
        s_release |-> $past(ext_ok) && $past(lock_ok))
        else $error("reset released without external reset or lock");

    a_strap_capture: assert property (
        s_release |-> q.strap == $past(strap_s))
        else $error("straps not captured at reset release");

    a_strap_hold: assert property (
        rel ##1 rel |-> $stable(q.strap))
        else $error("latched straps changed while running");

    a_debug_gating: assert property (
        rel && !debug_support_unit |-> !debug_unit_clk_en && !debug_bus_clk_en && eth_clk_en == 2'h0)
        else $error("debug clocks on with debug strap low");

    a_edcl0_off: assert property (
        s_eth_leave(0) ##0 q.strap[3:0] == 4'hF |-> ##1 !ethernet_debug_link_en[0])
        else $error("debug link 0 not disabled by all-ones nibble");

    a_edcl1_off: assert property (
        s_eth_leave(1) ##0 q.strap[7:4] == 4'hF |-> ##1 !ethernet_debug_link_en[1])
        else $error("debug link 1 not disabled by all-ones nibble");

    a_halt_debug: assert property (
        rel && debug_support_unit && $past(halt_request, 2) && $past(halt_request, 3) |-> cpu_debug_halt)
        else $error("halt request did not halt processors");

    a_watchdog_bit: assert property (
        rel && !debug_support_unit |-> wdog_enable == q.strap[13] && !cpu_debug_halt)
        else $error("watchdog bit does not follow halt strap");

    a_mem_width: assert property (
        q.strap[9] |-> !mem_data_64 && (upper_pins_pci != upper_pins_eth1))
        else $error("narrow memory did not free upper pins");

    a_dint_modes: assert property (
        q.strap[7] |-> !dint_enable && (dint_tc_all == !q.strap[6]))
        else $error("distributed interrupt mode decode wrong");

    // The synchroniser needs two edges after reset before the strap reaches the gate.
    a_ignore_lock: assert property (
        $past(rstn, 2) && $past(ignore_lock_strap, 2) && $past(ignore_lock_strap, 3) |-> pll_gate_open)
        else $error("ignore-lock strap did not open PLL gate");
endmodule

// >>> sim/bsc_board.sv
// Board model: strap pins, PLL lock pins and the external reset source.
// Assumes the bench changes cfg only while the on-chip reset is held.
`timescale 1ns/1ns

module bsc_board (
    input wire logic clk_sys,
    input wire logic sys_rst_n,
    input wire logic rel,
    input wire logic [13:0] cfg,
    input wire logic [2:0] locks,
    output logic [7:0] gpio_strap,
    output logic [5:0] straps,
    output logic external_system_reset_n,
    output logic [2:0] pll_lock
);
    initial begin
        gpio_strap = 8'h00;
        straps = 6'h00;
        external_system_reset_n = 1'b0;
        pll_lock = 3'h0;
    end

    always @(posedge clk_sys) begin
        external_system_reset_n <= rel;
        pll_lock <= locks;
        straps <= cfg[13:8];
        // Once the chip runs, the shared pins carry unrelated traffic, so the level keeps moving.
        if (sys_rst_n === 1'b1) begin
            gpio_strap <= ~gpio_strap;
        end else begin
            gpio_strap <= cfg[7:0];
        end
    end
endmodule

// >>> sim/bsc_top_tb_top.sv
// Self-checking bench for the strap capture block, APB master and board model.
// Assumes the board model drives every strap, lock and external reset pin.
`timescale 1ns/1ns

module bsc_top_tb_top;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, sys_rst_n, pll_gate_open, rel = 1'b0;
    logic [13:0] cfg = 14'h0;
    logic [2:0] locks = 3'h0, pll_lock;
    logic [7:0] gpio_strap;
    logic [5:0] straps;
    logic external_system_reset_n, debug_unit_clk_en, debug_bus_clk_en, cpu_debug_halt, wdog_enable, cpu0_start;
    logic [1:0] eth_clk_en, ethernet_debug_link_en;
    logic [3:0] ethernet_debug_link_nibble0, ethernet_debug_link_nibble1;
    logic mem_data_64, upper_pins_pci, upper_pins_eth1, mem_clk_external, tdc_set_elapsed, tdc_incr_elapsed;
    logic dint_enable, dint_ext_mode, dint_tc_all, dint_tc_flag_filter;
    int errors = 0, num_checks = 0, cycles = 0;

    always #50 clk_sys = ~clk_sys;

    bsc_board u_bsc_board (.clk_sys, .sys_rst_n, .rel, .cfg, .locks, .gpio_strap, .straps,
        .external_system_reset_n, .pll_lock);

    bsc_top u_bsc_top (.clk_sys, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .gpio_strap, .debug_unit_enable_strap(straps[0]), .halt_request(straps[5]),
        .mem_width_strap(straps[1]), .pin_reuse_strap(straps[2]), .memory_clock_source_strap(straps[3]),
        .ignore_lock_strap(straps[4]), .external_system_reset_n, .pll_lock, .sys_rst_n, .pll_gate_open,
        .debug_unit_clk_en, .debug_bus_clk_en, .eth_clk_en, .ethernet_debug_link_en, .ethernet_debug_link_nibble0,
        .ethernet_debug_link_nibble1, .cpu_debug_halt, .wdog_enable, .cpu0_start, .mem_data_64, .upper_pins_pci,
        .upper_pins_eth1, .mem_clk_external, .tdc_set_elapsed, .tdc_incr_elapsed, .dint_enable,
        .dint_ext_mode, .dint_tc_all, .dint_tc_flag_filter);

    // ----------------------------------------------------------------
    // Bench tasks
    // ----------------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Called just after a rising edge; the request holds until pready is sampled high.
    task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Full power-up with one strap set, then decode and strap register checks.
    task automatic boot(input logic [13:0] c);
        logic [7:0] g;
        logic d, h, dis0, dis1;
        int n;
        g = c[7:0];
        d = c[8];
        h = c[13];
        dis0 = &g[3:0];
        dis1 = &g[7:4];
        n = 0;
        rel <= 1'b0;
        wait_cyc(8);
        chk("held", 32'h0, 32'(sys_rst_n));
        cfg <= c;
        locks <= c[12] ? 3'b010 : 3'b111;
        wait_cyc(4);
        rel <= 1'b1;
        while (sys_rst_n !== 1'b1 && n < 30) begin
            @(posedge clk_sys);
            n++;
        end
        wait_cyc(3);
        @(negedge clk_sys);
        chk("release", 32'h1, 32'(sys_rst_n));
        chk("debug", 32'({d, d, d, d, d & ~dis1, d & ~dis0, d & h, ~d & h, d | h}),
            32'({debug_unit_clk_en, debug_bus_clk_en, eth_clk_en, ethernet_debug_link_en, cpu_debug_halt,
            wdog_enable, cpu0_start}));
        chk("memory", 32'({~c[9], c[9] & c[10], c[9] & ~c[10], c[11], 1'b1}), 32'({mem_data_64,
            upper_pins_pci, upper_pins_eth1, mem_clk_external, pll_gate_open}));
        chk("gpio", 32'({g[3:0], g[5:4], g[1:0], g[1], g[0], ~g[7], g[7:6] == 2'b01, g[7:6] == 2'b10,
            g[7:6] == 2'b11}), 32'({ethernet_debug_link_nibble0, ethernet_debug_link_nibble1, tdc_incr_elapsed, tdc_set_elapsed, dint_enable,
            dint_ext_mode, dint_tc_all, dint_tc_flag_filter}));
        @(posedge clk_sys);
        apb(1'b0, 32'h0, 32'h0);
        chk("strap reg", {18'h0, c}, rd);
        // Cycle both Ethernet controllers through reset while the shared pins toggle.
        apb(1'b1, 32'h8, 32'h3);
        apb(1'b1, 32'h8, 32'h0);
        apb(1'b0, 32'h8, 32'h0);
        chk("ethernet_debug_link flags", {28'h0, dis1, dis0, 2'b00}, rd);
        chk("ethernet_debug_link link", {30'h0, d & ~dis1, d & ~dis0}, 32'(ethernet_debug_link_en));
        $display("test boot %h done", c);
    endtask

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end

    initial begin
        wait_cyc(4);
        rstn <= 1'b1;
        wait_cyc(2);
        // One lock missing and lock not ignored: the chip must stay in reset.
        cfg <= 14'h0100;
        locks <= 3'b101;
        rel <= 1'b1;
        wait_cyc(12);
        chk("no lock", 32'h0, 32'(sys_rst_n));
        $display("test lock wait done");
        boot(14'h210F);
        boot(14'h3E5A);
        boot(14'h0CA5);
        boot(14'h03F6);
        apb(1'b0, 32'h4, 32'h0);
        chk("status", 32'h19, rd);
        apb(1'b1, 32'h8, 32'h3);
        chk("eth hold", 32'h0, 32'({eth_clk_en, ethernet_debug_link_en}));
        apb(1'b1, 32'h8, 32'h0);
        wait_cyc(2);
        apb(1'b0, 32'h8, 32'h0);
        chk("eth flags", 32'h8, rd);
        chk("link en", 32'h1, 32'(ethernet_debug_link_en));
        apb(1'b1, 32'h0, 32'hFFFF);
        apb(1'b0, 32'h0, 32'h0);
        chk("ro strap", 32'h03F6, rd);
        apb(1'b0, 32'hC, 32'h0);
        chk("unmapped", 32'h1, 32'(err));
        apb(1'b0, 32'h2, 32'h0);
        chk("misaligned", 32'h1, 32'(err));
        apb(1'b0, 32'h100, 32'h0);
        chk("upper addr", 32'h1, 32'(err));
        chk("error data", 32'h0, rd);
        $display("test registers done");
        stop_test();
    end
endmodule
